// File: hdl/page_mapper_pkg.sv
// Constants shared by the memory page mapper
// Behaviour
// - Direct page base always readable; writes anytime in special mode, once in normal mode.
// - Direct page base places a 256-byte direct page, local and global schemes alike.
// - Direct addressing: base gives local bits 15:8, operand gives low byte.
// - Resource select 1 routes global 0x04000-0x07FFF to internal NVM resources.
// - Resource select 0 routes that range to program flash; bit always read/write.
// - Four-bit window page index maps a 16K global page into local 0x8000-0xBFFF.
// - Window page readable/writable by bus anytime and by CPU far call/return.
// - Far call/return page update completes before the instruction ends.
// - Local 0x0000-0x3FFF maps to fixed global page 0xC.
// - Local 0x4000-0x7FFF always maps to fixed global page 0xD.
// - Local 0xC000-0xFFFF is unpaged, always global page 0xF.
// - Window page index resets to 0xE giving linear flash after reset.
// - Global addresses are 18 bits; page index picks one of sixteen 16KB pages.
// - Active debug shows debug tables at local 0xFF00-0xFFFF, hiding shared resources.
// - Active debug also shows them at 0xBF00-0xBFFF when window page is 0x0F.
// - Debug resources selected only in debug read/write cycles, never user code; CPU local addresses also select them during such cycles.
// - Debug expansion same scheme; debug page used only when enabled and commanding.
// - Window page and debug page registers readable/writable by the debug unit.
// - Normal single-chip mode has no external bus; all accesses stay on chip.
// - Mode pin, synchronised and captured on the fourth clock after reset release, selects normal or special single-chip mode.
package page_mapper_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DIRECT_PAGE_BASE = 8'h11;
  localparam logic [7:0] IDX_MAP_CONTROL = 8'h13;
  localparam logic [7:0] IDX_PROGRAM_WINDOW_PAGE = 8'h15;
  localparam logic [7:0] IDX_DEBUG_WINDOW_PAGE = 8'h18;
  localparam logic [7:0] IDX_MODE_STATUS = 8'h19;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int NVM_RESOURCE_SELECT_BIT = 0;
  localparam int STATUS_NORMAL_BIT = 0;
  localparam int STATUS_DIRECT_LOCKED_BIT = 1;
  localparam int STATUS_MODE_VALID_BIT = 2;
  localparam logic [7:0] DIRECT_PAGE_BASE_RESET = 8'h00;
  localparam logic NVM_RESOURCE_SELECT_RESET = 1'b0;
  localparam logic [3:0] PROGRAM_WINDOW_PAGE_RESET = 4'hE;
  localparam logic [3:0] DEBUG_WINDOW_PAGE_RESET = 4'h0;
  localparam logic MODE_PIN_NORMAL = 1'b1;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int GLOBAL_ADDR_WIDTH = 18;
  localparam logic [3:0] FIXED_PAGE_LOW = 4'hC;
  localparam logic [3:0] FIXED_PAGE_MID = 4'hD;
  localparam logic [3:0] FIXED_PAGE_TOP = 4'hF;
  localparam logic [1:0] LOCAL_BLOCK_WINDOW = 2'b10;
  localparam logic [1:0] LOCAL_BLOCK_LOW = 2'b00;
  localparam logic [1:0] LOCAL_BLOCK_MID = 2'b01;
  localparam logic [3:0] NVM_GLOBAL_PAGE = 4'h1;
  localparam logic [7:0] DEBUG_AREA_TOP = 8'hFF;
  localparam logic [7:0] DEBUG_AREA_WINDOW = 8'hBF;
  localparam logic [3:0] DEBUG_WINDOW_PAGE_VALUE = 4'hF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CAPTURE_DELAY = 2'h3;

endpackage

// File: hdl/memory_page_mapper.sv
// Memory page mapper: page registers, mode capture and address expansion
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module memory_page_mapper
  import page_mapper_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Mode strap
  input wire logic i_mode_select_pin,
  // CPU local side
  input wire logic [15:0] i_cpu_local_addr,
  input wire logic i_cpu_direct_mode,
  input wire logic i_cpu_far_page_we,
  input wire logic [3:0] i_cpu_far_page_data,
  // Debug unit local side
  input wire logic [15:0] i_bdm_local_addr,
  input wire logic i_bdm_active,
  input wire logic i_debug_read_cycle,
  input wire logic i_debug_write_cycle,
  input wire logic i_debug_page_enable,
  input wire logic i_debug_cmd_active,
  // CPU global side
  output logic [17:0] o_cpu_global_addr,
  output logic o_cpu_debug_select,
  output logic o_cpu_nvm_hit,
  output logic o_cpu_pflash_hit,
  // Debug unit global side
  output logic [17:0] o_bdm_global_addr,
  output logic o_bdm_debug_select,
  output logic o_bdm_nvm_hit,
  output logic o_bdm_pflash_hit,
  // Register views and mode
  output logic [3:0] o_program_window_page,
  output logic o_normal_single_chip,
  output logic o_external_bus_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] direct_page_base;
    logic direct_written;
    logic nvm_resource_select;
    logic [3:0] window_page_index;
    logic [3:0] debug_window_page;
    logic mode_sync1;
    logic mode_sync2;
    logic [1:0] capture_count;
    logic mode_valid;
    logic normal_single_chip;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [17:0] cpu_gaddr;
    logic cpu_dbg;
    logic cpu_nvm;
    logic cpu_flash;
    logic [17:0] bdm_gaddr;
    logic bdm_dbg;
    logic bdm_nvm;
    logic bdm_flash;
  } state_t;

  state_t state;
  state_t next_state;

  // ----------------------------------------------------------------
  // Address expansion helpers
  // ----------------------------------------------------------------
  function automatic logic [17:0] expand(input logic [15:0] local_addr,
                                         input logic [3:0] page);
    logic [3:0] sel_page;
    sel_page = FIXED_PAGE_TOP;
    if (local_addr[15:14] == LOCAL_BLOCK_LOW) begin
      sel_page = FIXED_PAGE_LOW;
    end else if (local_addr[15:14] == LOCAL_BLOCK_MID) begin
      sel_page = FIXED_PAGE_MID;
    end else if (local_addr[15:14] == LOCAL_BLOCK_WINDOW) begin
      sel_page = page;
    end
    expand = {sel_page, local_addr[13:0]};
  endfunction

  function automatic logic debug_area(input logic [15:0] local_addr,
                                      input logic [3:0] page);
    debug_area = (local_addr[15:8] == DEBUG_AREA_TOP) ||
                 ((local_addr[15:8] == DEBUG_AREA_WINDOW) &&
                  (page == DEBUG_WINDOW_PAGE_VALUE));
  endfunction

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic wb_req;
  logic wb_commit;
  logic [7:0] wb_index;
  logic direct_locked;
  logic debug_cycle;
  logic [3:0] cpu_page;
  logic [3:0] bdm_page;
  logic [15:0] cpu_local;
  logic [17:0] cpu_exp;
  logic [17:0] bdm_exp;
  logic cpu_dbg_hit;
  logic bdm_dbg_hit;
  logic [31:0] read_word;

  assign wb_req = i_wb_cyc && i_wb_stb;
  assign wb_commit = wb_req && state.wb_ack;
  assign wb_index = i_wb_adr[9:2];
  assign direct_locked = state.normal_single_chip && state.direct_written;
  assign debug_cycle = i_bdm_active && (i_debug_read_cycle || i_debug_write_cycle);
  // Debug page steers both masters only while commanding
  assign bdm_page = (i_debug_page_enable && i_debug_cmd_active) ?
                    state.debug_window_page : state.window_page_index;
  assign cpu_page = bdm_page;
  // Direct addressing builds the local address from the base
  assign cpu_local = i_cpu_direct_mode ?
                     {state.direct_page_base, i_cpu_local_addr[7:0]} :
                     i_cpu_local_addr;
  assign cpu_exp = expand(cpu_local, cpu_page);
  assign bdm_exp = expand(i_bdm_local_addr, bdm_page);
  assign cpu_dbg_hit = debug_cycle && debug_area(cpu_local, cpu_page);
  assign bdm_dbg_hit = debug_cycle && debug_area(i_bdm_local_addr, bdm_page);

  always_comb begin
    read_word = 32'h0000_0000;
    if (wb_index == IDX_DIRECT_PAGE_BASE) begin
      read_word[7:0] = state.direct_page_base;
    end else if (wb_index == IDX_MAP_CONTROL) begin
      read_word[NVM_RESOURCE_SELECT_BIT] = state.nvm_resource_select;
    end else if (wb_index == IDX_PROGRAM_WINDOW_PAGE) begin
      read_word[3:0] = state.window_page_index;
    end else if (wb_index == IDX_DEBUG_WINDOW_PAGE) begin
      read_word[3:0] = state.debug_window_page;
    end else if (wb_index == IDX_MODE_STATUS) begin
      read_word[STATUS_NORMAL_BIT] = state.normal_single_chip;
      read_word[STATUS_DIRECT_LOCKED_BIT] = direct_locked;
      read_word[STATUS_MODE_VALID_BIT] = state.mode_valid;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Mode strap, captured once the synchroniser has settled
    next_state.mode_sync1 = i_mode_select_pin;
    next_state.mode_sync2 = state.mode_sync1;
    if (!state.mode_valid) begin
      if (state.capture_count == MODE_CAPTURE_DELAY) begin
        next_state.mode_valid = 1'b1;
        next_state.normal_single_chip = (state.mode_sync2 == MODE_PIN_NORMAL);
      end else begin
        next_state.capture_count = state.capture_count + 2'h1;
      end
    end
    // Bus slave: one wait state, ack for one cycle
    next_state.wb_ack = wb_req && !state.wb_ack;
    if (wb_req && !state.wb_ack) begin
      next_state.wb_dat = read_word;
    end else if (!wb_req) begin
      next_state.wb_dat = 32'h0000_0000;
    end
    if (wb_commit && i_wb_we && i_wb_sel[0]) begin
      if (wb_index == IDX_DIRECT_PAGE_BASE) begin
        if (!direct_locked) begin
          next_state.direct_page_base = i_wb_dat[7:0];
          next_state.direct_written = 1'b1;
        end
      end else if (wb_index == IDX_MAP_CONTROL) begin
        next_state.nvm_resource_select = i_wb_dat[NVM_RESOURCE_SELECT_BIT];
      end else if (wb_index == IDX_PROGRAM_WINDOW_PAGE) begin
        next_state.window_page_index = i_wb_dat[3:0];
      end else if (wb_index == IDX_DEBUG_WINDOW_PAGE) begin
        next_state.debug_window_page = i_wb_dat[3:0];
      end
    end
    // Far call/return path wins and lands on the next edge
    if (i_cpu_far_page_we) begin
      next_state.window_page_index = i_cpu_far_page_data;
    end
    // Registered translation; debug hits hide shared resources
    next_state.cpu_gaddr = cpu_exp;
    next_state.cpu_dbg = cpu_dbg_hit;
    next_state.cpu_nvm = !cpu_dbg_hit && (cpu_exp[17:14] == NVM_GLOBAL_PAGE) &&
                         state.nvm_resource_select;
    next_state.cpu_flash = !cpu_dbg_hit && (cpu_exp[17:14] == NVM_GLOBAL_PAGE) &&
                           !state.nvm_resource_select;
    next_state.bdm_gaddr = bdm_exp;
    next_state.bdm_dbg = bdm_dbg_hit;
    next_state.bdm_nvm = !bdm_dbg_hit && (bdm_exp[17:14] == NVM_GLOBAL_PAGE) &&
                         state.nvm_resource_select;
    next_state.bdm_flash = !bdm_dbg_hit && (bdm_exp[17:14] == NVM_GLOBAL_PAGE) &&
                           !state.nvm_resource_select;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
      state.direct_page_base <= DIRECT_PAGE_BASE_RESET;
      state.nvm_resource_select <= NVM_RESOURCE_SELECT_RESET;
      state.window_page_index <= PROGRAM_WINDOW_PAGE_RESET;
      state.debug_window_page <= DEBUG_WINDOW_PAGE_RESET;
      state.normal_single_chip <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_wb_dat = state.wb_dat;
  assign o_wb_ack = state.wb_ack;
  assign o_cpu_global_addr = state.cpu_gaddr;
  assign o_cpu_debug_select = state.cpu_dbg;
  assign o_cpu_nvm_hit = state.cpu_nvm;
  assign o_cpu_pflash_hit = state.cpu_flash;
  assign o_bdm_global_addr = state.bdm_gaddr;
  assign o_bdm_debug_select = state.bdm_dbg;
  assign o_bdm_nvm_hit = state.bdm_nvm;
  assign o_bdm_pflash_hit = state.bdm_flash;
  assign o_program_window_page = state.window_page_index;
  assign o_normal_single_chip = state.normal_single_chip;
  // No external bus in either single-chip mode
  assign o_external_bus_enable = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DIRECT_LOCKED: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_commit && i_wb_we && (wb_index == IDX_DIRECT_PAGE_BASE) && direct_locked)
    |=> $stable(state.direct_page_base))
    else $error("direct page base changed after lock");

  AST_DIRECT_SPECIAL_WRITE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_commit && i_wb_we && i_wb_sel[0] && (wb_index == IDX_DIRECT_PAGE_BASE) &&
     !state.normal_single_chip)
    |=> (state.direct_page_base == $past(i_wb_dat[7:0])))
    else $error("direct page write lost in special mode");

  AST_LOW_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (cpu_local[15:14] == 2'b00) |=> (o_cpu_global_addr[17:14] == 4'hC))
    else $error("low block not on page C");

  AST_MID_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_bdm_local_addr[15:14] == 2'b01) |=> (o_bdm_global_addr[17:14] == 4'hD))
    else $error("mid block not on page D");

  AST_TOP_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (cpu_local[15:14] == 2'b11) |=> (o_cpu_global_addr == {4'hF, $past(cpu_local[13:0])}))
    else $error("top block not on page F");

  AST_WINDOW_PAGE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (cpu_local[15:14] == 2'b10)
    |=> (o_cpu_global_addr == {$past(cpu_page), $past(cpu_local[13:0])}))
    else $error("window not mapped through page index");

  AST_DIRECT_ADDR: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cpu_direct_mode
    |=> (o_cpu_global_addr[13:0] ==
         {$past(state.direct_page_base[5:0]), $past(i_cpu_local_addr[7:0])}))
    else $error("direct address not built from base");

  AST_NVM_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (o_cpu_global_addr[17:14] == 4'h1 && !o_cpu_debug_select && $past(state.nvm_resource_select))
    |-> (o_cpu_nvm_hit && !o_cpu_pflash_hit))
    else $error("nvm range not routed to nvm");

  AST_FLASH_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (o_bdm_global_addr[17:14] == 4'h1 && !o_bdm_debug_select && !$past(state.nvm_resource_select))
    |-> (o_bdm_pflash_hit && !o_bdm_nvm_hit))
    else $error("nvm range not routed to flash");

  AST_FAR_PAGE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cpu_far_page_we |=> (o_program_window_page == $past(i_cpu_far_page_data)))
    else $error("far page update late");

  AST_DEBUG_TOP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (debug_cycle && i_bdm_local_addr[15:8] == 8'hFF)
    ##1 1'b1 |-> (o_bdm_debug_select && !o_bdm_nvm_hit && !o_bdm_pflash_hit))
    else $error("debug area not selected");

  AST_DEBUG_WINDOW: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (debug_cycle && i_bdm_local_addr[15:8] == 8'hBF && bdm_page == 4'hF) |=> o_bdm_debug_select)
    else $error("debug window alias missing");

  AST_DEBUG_HIDDEN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !debug_cycle |=> (!o_cpu_debug_select && !o_bdm_debug_select))
    else $error("debug area visible outside debug cycles");

  AST_DEBUG_PAGE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_debug_page_enable && i_debug_cmd_active && i_bdm_local_addr[15:14] == 2'b10)
    |=> (o_bdm_global_addr[17:14] == $past(state.debug_window_page)))
    else $error("debug page not used");

  AST_WB_ACK_PULSE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_req && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single pulse");

  AST_NO_EXT_BUS: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_normal_single_chip |-> !o_external_bus_enable)
    else $error("external bus enabled");

  AST_MID_BLOCK_CPU: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (cpu_local[15:14] == 2'b01)
    |=> (o_cpu_global_addr[17:14] == 4'hD))
    else $error("cpu mid block not on page D");

  AST_LOW_BLOCK_BDM: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_bdm_local_addr[15:14] == 2'b00)
    |=> (o_bdm_global_addr[17:14] == 4'hC))
    else $error("debug low block not on page C");

  AST_TOP_BLOCK_BDM: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_bdm_local_addr[15:14] == 2'b11)
    |=> (o_bdm_global_addr[17:14] == 4'hF))
    else $error("debug top block not on page F");

  AST_PAGE_FALLBACK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!(i_debug_page_enable && i_debug_cmd_active) && i_bdm_local_addr[15:14] == 2'b10)
    |=> (o_bdm_global_addr[17:14] == $past(state.window_page_index)))
    else $error("window page not used");

  AST_CPU_DEBUG_TOP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (debug_cycle && cpu_local[15:8] == 8'hFF)
    |=> (o_cpu_debug_select && !o_cpu_nvm_hit && !o_cpu_pflash_hit))
    else $error("cpu debug area not selected");

  AST_MAP_WRITE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_commit && i_wb_we && i_wb_sel[0] && wb_index == IDX_MAP_CONTROL)
    |=> (state.nvm_resource_select == $past(i_wb_dat[NVM_RESOURCE_SELECT_BIT])))
    else $error("resource select write lost");

  AST_PAGE_WRITE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_commit && i_wb_we && i_wb_sel[0] && wb_index == IDX_PROGRAM_WINDOW_PAGE &&
     !i_cpu_far_page_we)
    |=> (o_program_window_page == $past(i_wb_dat[3:0])))
    else $error("window page write lost");

  AST_DEBUG_PAGE_WRITE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_commit && i_wb_we && i_wb_sel[0] && wb_index == IDX_DEBUG_WINDOW_PAGE)
    |=> (state.debug_window_page == $past(i_wb_dat[3:0])))
    else $error("debug page write lost");

  AST_PAGE_READ: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wb_req && !o_wb_ack && wb_index == IDX_PROGRAM_WINDOW_PAGE)
    |=> (o_wb_dat == {28'h0000000, $past(state.window_page_index)}))
    else $error("window page read wrong");

  AST_MODE_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(state.mode_valid)
    |-> (state.normal_single_chip == $past(state.mode_sync2)))
    else $error("mode not taken from strap");

  AST_MODE_HELD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    state.mode_valid
    |=> $stable(state.normal_single_chip))
    else $error("mode changed after capture");

endmodule
`default_nettype wire

// File: tb/local_side_model.sv
// Local side model: CPU core and debug unit issuing local addresses
`timescale 1ns/1ps
`default_nettype none
module local_side_model (
  // Clock
  input wire logic i_mclk,
  // CPU side
  output logic [15:0] o_cpu_local_addr,
  output logic o_cpu_direct_mode,
  output logic o_cpu_far_page_we,
  output logic [3:0] o_cpu_far_page_data,
  // Debug unit side
  output logic [15:0] o_bdm_local_addr,
  output logic [4:0] o_bdm_ctl
);
  initial begin
    o_cpu_local_addr = 16'h0000;
    o_cpu_direct_mode = 1'b0;
    o_cpu_far_page_we = 1'b0;
    o_cpu_far_page_data = 4'h0;
    o_bdm_local_addr = 16'h0000;
    o_bdm_ctl = 5'h00;
  end
  // One access of each master; ctl is {active, read, write, page enable, command}
  task automatic access(input logic [15:0] ca, input logic dm, input logic [15:0] ba,
                        input logic [4:0] ctl);
    @(posedge i_mclk);
    o_cpu_local_addr <= ca;
    o_cpu_direct_mode <= dm;
    o_bdm_local_addr <= ba;
    o_bdm_ctl <= ctl;
  endtask
  // Far call page update, one-cycle strobe
  task automatic far_write(input logic [3:0] pg);
    @(posedge i_mclk);
    o_cpu_far_page_we <= 1'b1;
    o_cpu_far_page_data <= pg;
    @(posedge i_mclk);
    o_cpu_far_page_we <= 1'b0;
    o_cpu_far_page_data <= ~pg;
  endtask
endmodule
`default_nettype wire

// File: tb/test_memory_page_mapper.sv
// Self-checking testbench of the memory page mapper
`timescale 1ns/1ps
`default_nettype none
module test_memory_page_mapper;
  import page_mapper_pkg::*;
  logic i_mclk, i_reset_n, cyc, stb, we, mode_pin, ack, dm, fwe;
  logic [9:0] adr;
  logic [3:0] sel, fdat;
  logic [31:0] wdat, rdat, q;
  logic [15:0] ca, ba;
  logic [4:0] ctl;
  logic [15:0] mca, mba;
  logic [4:0] mctl;
  logic [17:0] cga, bga;
  logic cds, cnv, cpf, bds, bnv, bpf, ext, nsc;
  logic [3:0] wpage;
  logic [3:0] pg, dpg, ep;
  logic [7:0] dp_base;
  logic nvm;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 5;
  memory_page_mapper i_memory_page_mapper (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_mode_select_pin(mode_pin),
    .i_cpu_local_addr(mca), .i_cpu_direct_mode(dm), .i_cpu_far_page_we(fwe),
    .i_cpu_far_page_data(fdat), .i_bdm_local_addr(mba), .i_bdm_active(mctl[4]),
    .i_debug_read_cycle(mctl[3]), .i_debug_write_cycle(mctl[2]),
    .i_debug_page_enable(mctl[1]), .i_debug_cmd_active(mctl[0]),
    .o_cpu_global_addr(cga), .o_cpu_debug_select(cds), .o_cpu_nvm_hit(cnv),
    .o_cpu_pflash_hit(cpf), .o_bdm_global_addr(bga), .o_bdm_debug_select(bds),
    .o_bdm_nvm_hit(bnv), .o_bdm_pflash_hit(bpf), .o_program_window_page(wpage),
    .o_normal_single_chip(nsc), .o_external_bus_enable(ext));
  local_side_model i_local_side_model (.i_mclk(i_mclk), .o_cpu_local_addr(mca),
    .o_cpu_direct_mode(dm), .o_cpu_far_page_we(fwe), .o_cpu_far_page_data(fdat),
    .o_bdm_local_addr(mba), .o_bdm_ctl(mctl));
  // ----------------------------------------------------------------
  // Clock, checks and bus cycles
  // ----------------------------------------------------------------
  initial i_mclk = 1'b0;
  always #12.5 i_mclk = ~i_mclk;
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_map(input string nm, input logic [20:0] e, input logic [20:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n = 0;
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk_reg("bus answer", 32'h1, {31'h0, ack});
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Expected {global, debug select, nvm hit, flash hit}
  function automatic logic [20:0] exp_map(input logic [15:0] la, input logic [3:0] p,
                                         input logic nv, input logic dbg);
    logic [3:0] gp;
    logic ds;
    gp = (la[15:14] == 2'b00) ? 4'hC : (la[15:14] == 2'b01) ? 4'hD :
         (la[15:14] == 2'b10) ? p : 4'hF;
    ds = dbg && (la[15:8] == 8'hFF || (la[15:8] == 8'hBF && p == 4'hF));
    return {gp, la[13:0], ds, !ds && gp == 4'h1 && nv, !ds && gp == 4'h1 && !nv};
  endfunction
  task automatic do_reset(input logic m);
    mode_pin <= m;
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(25ns * 20000);
    n_errors++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    do_reset(1'b0);
    chk_reg("window page out", 32'hE, {28'h0, wpage});
    wb(1'b0, IDX_PROGRAM_WINDOW_PAGE, 32'h0);
    chk_reg("window page", 32'hE, q);
    wb(1'b0, IDX_DIRECT_PAGE_BASE, 32'h0);
    chk_reg("direct base", 32'h0, q);
    wb(1'b0, IDX_MODE_STATUS, 32'h0);
    chk_reg("special status", 32'h4, q);
    chk_reg("mode out", 32'h0, {31'h0, nsc});
    for (int i = 0; i < 2; i++) begin
      dp_base = i ? 8'h5A : 8'h04;
      wb(1'b1, IDX_DIRECT_PAGE_BASE, {24'h0, dp_base});
      wb(1'b0, IDX_DIRECT_PAGE_BASE, 32'h0);
      chk_reg("special direct", {24'h0, dp_base}, q);
    end
    wb(1'b1, 8'h30, 32'hFF);
    wb(1'b0, 8'h30, 32'h0);
    chk_reg("unmapped", 32'h0, q);
    i_local_side_model.far_write(4'h7);
    @(negedge i_mclk);
    chk_reg("far page", 32'h7, {28'h0, wpage});
    wb(1'b0, IDX_PROGRAM_WINDOW_PAGE, 32'h0);
    chk_reg("far page read", 32'h7, q);
    for (int i = 0; i < 60; i++) begin
      pg = 4'($random(seed));
      dpg = 4'($random(seed));
      nvm = 1'($random(seed));
      ca = 16'($random(seed));
      ba = 16'($random(seed));
      ctl = 5'($random(seed));
      if (ctl[1] && ctl[0]) begin
        ctl[4] = 1'b0;
      end
      if (i < 8) begin
        pg = (i < 4) ? 4'hF : 4'h1;
        nvm = i[0];
        ca = (i < 4) ? {i[1] ? 8'hFF : 8'hBF, 8'h20} : 16'h8123;
        ba = ca;
        ctl = i[0] ? 5'b11000 : 5'b10100;
      end
      wb(1'b1, IDX_PROGRAM_WINDOW_PAGE, {28'h0, pg});
      wb(1'b1, IDX_DEBUG_WINDOW_PAGE, {28'h0, dpg});
      wb(1'b1, IDX_MAP_CONTROL, {31'h0, nvm});
      wb(1'b0, IDX_MAP_CONTROL, 32'h0);
      chk_reg("resource select", {31'h0, nvm}, q);
      i_local_side_model.access(ca, (i >= 8) && ca[15], ba, ctl);
      @(posedge i_mclk);
      @(negedge i_mclk);
      ep = (ctl[1] && ctl[0]) ? dpg : pg;
      chk_map("cpu map", exp_map(((i >= 8) && ca[15]) ? {dp_base, ca[7:0]} : ca, ep, nvm,
              ctl[4] && (ctl[3] || ctl[2])), {cga, cds, cnv, cpf});
      chk_map("debug map", exp_map(ba, ep, nvm, ctl[4] && (ctl[3] || ctl[2])),
              {bga, bds, bnv, bpf});
      chk_reg("window page out", {28'h0, pg}, {28'h0, wpage});
    end
    do_reset(1'b1);
    chk_reg("window page out", 32'hE, {28'h0, wpage});
    wb(1'b0, IDX_MODE_STATUS, 32'h0);
    chk_reg("normal status", 32'h5, q);
    chk_reg("mode out", 32'h1, {31'h0, nsc});
    wb(1'b1, IDX_DIRECT_PAGE_BASE, 32'h04);
    wb(1'b1, IDX_DIRECT_PAGE_BASE, 32'h33);
    wb(1'b0, IDX_DIRECT_PAGE_BASE, 32'h0);
    chk_reg("write once", 32'h04, q);
    i_local_side_model.access(16'hC012, 1'b1, 16'h0000, 5'h00);
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk_map("direct access", {4'hC, 14'h0412, 3'b000}, {cga, cds, cnv, cpf});
    chk_reg("external bus", 32'h0, {31'h0, ext});
    stop_test();
  end
endmodule
`default_nettype wire
